// >>> rtl/iss_pkg.sv
// iss_pkg: constants for the i2c slave status and async detect block
// assumes: 16-bit register port, clk_sys at 200 MHz
// Functional notes
// - with filter_on, noise-filter data and clock pins before use
// - async detect own-address match raises bus event, answers NAK
// - async detect on takes bus inputs unfiltered
// - async detect on blocks all data transfer
// - comm_active low: own address gets no answer, seen as NAK
// - summary bit D7 is set while any of six flags is set
// - stretch off: transmit start with no written data sets D5
// - stretch off: received byte overwriting unread data sets D5
// - D0 and D2 to D5 stay set until software writes 1 to clear
// - release pin low over five cycles sets flag, frees the bus
// - bus_release_on low: pin pulses ignored, flag not set
// - sent bits compared with sensed line; difference sets D3
// - async detect mode: own NAK against other ACK sets no D3
// - own address seen in async detect mode sets D2
// - master acknowledge recorded in D1, 1 meaning NAK
// - after a sent byte, NAK sets D1 and ACK clears it
// - stop or repeated start while addressed sets D0, resets protocol
`default_nettype none
package iss_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_TX = 16'h4360;
  localparam logic [15:0] REG_RX = 16'h4362;
  localparam logic [15:0] REG_OWN = 16'h4364;
  localparam logic [15:0] REG_CTL = 16'h4366;
  localparam logic [15:0] REG_STAT = 16'h4368;
  localparam logic [15:0] REG_ACC = 16'h436A;
  localparam logic [15:0] REG_IEN = 16'h436C;
  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam int CTL_W = 8;
  localparam int CTL_COMM = 0;
  localparam int CTL_ASYNC = 1;
  localparam int CTL_FILT = 2;
  localparam int CTL_STR = 3;
  localparam int CTL_BFR = 4;
  localparam int CTL_NAKANS = 5;
  localparam int CTL_ON = 7;
  localparam logic [7:0] CTL_MASK = 8'hBF;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam int OWN_W = 7;
  localparam logic [6:0] OWN_RST = 7'h00;
  localparam int FLAG_W = 6;
  localparam int F_STOP = 0;
  localparam int F_NAK = 1;
  localparam int F_ASYNC = 2;
  localparam int F_DMS = 3;
  localparam int F_BFR = 4;
  localparam int F_UOV = 5;
  localparam int F_SUM = 7;
  localparam logic [5:0] FLAG_RST = 6'h00;
  localparam logic [5:0] KEEP_MASK = 6'h3D;
  localparam int IEN_BUS_EVENT_SUMMARY = 2;
  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [2:0] REL_MIN_CYC = 3'h5;
  localparam logic [2:0] REL_SAT = 3'h6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int FILT_LEN = 3;
  localparam logic [2:0] FILT_ONES = 3'h7;
  localparam logic [2:0] FILT_ZERO = 3'h0;
endpackage
`default_nettype wire

// >>> rtl/iss_pin_filter.sv
// iss_pin_filter: synchronisers and noise filter for the bus pins
// assumes: pins are asynchronous to clk_sys and idle high
`timescale 1ns/1ps
`default_nettype none
module iss_pin_filter
  import iss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic rel_pin_n,
  input wire logic filter_on,
  input wire logic bypass,
  output logic scl_f,
  output logic sda_f,
  output logic rel_n_s
);
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [FILT_LEN-1:0] hist_r [2];
  logic [1:0] out_r;
  logic sda_s;

  // two flops per pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
    end else begin
      s1_r <= {rel_pin_n, sda_pin, scl_pin};
      s2_r <= s1_r;
    end
  end

  // ---------------------------------------------------------------
  // filter
  // ---------------------------------------------------------------
  // a level passes once it held for the whole history
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        hist_r[i] <= FILT_ONES;
        out_r[i] <= 1'h1;
      end else begin
        hist_r[i] <= {hist_r[i][FILT_LEN-2:0], s2_r[i]};
        if (bypass || !filter_on) begin
          out_r[i] <= s2_r[i];
        end else if (hist_r[i] == FILT_ONES) begin
          out_r[i] <= 1'h1;
        end else if (hist_r[i] == FILT_ZERO) begin
          out_r[i] <= 1'h0;
        end
      end
    end
  end

  assign sda_s = s2_r[1];
  assign scl_f = out_r[0];
  assign sda_f = out_r[1];
  assign rel_n_s = s2_r[2];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_bypass_raw: assert property (
    bypass |=> sda_f == $past(sda_s))
    else $error("bypass did not pass raw data line");
  a_filter_hold: assert property (
    filter_on && !bypass && hist_r[1] != FILT_ONES &&
    hist_r[1] != FILT_ZERO |=> $stable(sda_f))
    else $error("filter passed an unsteady level");
endmodule
`default_nettype wire

// >>> rtl/iss_status_core.sv
// iss_status_core: i2c slave protocol, event flags, async detect, bus release
// assumes: plain register port on clk_sys, bus pins and release pin async
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module iss_status_core
  import iss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic clock_line_pin_in,
  output logic clock_line_pin_out,
  output logic clock_line_pin_oe,
  input wire logic data_line_pin_in,
  output logic data_line_pin_out,
  output logic data_line_pin_oe,
  input wire logic bus_release_pin_n,
  output logic bus_event_irq
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_MACK
  } iss_state_e;

  iss_state_e state_r;
  logic [CTL_W-1:0] ctl_r;
  logic [OWN_W-1:0] own_r;
  logic ien_r;
  logic [7:0] tx_byte_r;
  logic [7:0] rx_byte_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic [2:0] rel_cnt_r;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] set_v;
  logic [15:0] rdata_r;
  logic tx_pending_r;
  logic tx_empty_r;
  logic rx_ready_r;
  logic selected_r;
  logic rw_r;
  logic busy_r;
  logic pres_r;
  logic drv_low_r;
  logic scl_d_r;
  logic sda_d_r;
  logic irq_r;
  logic scl_f;
  logic sda_f;
  logic rel_n_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic async_on;
  logic rel_hit;
  logic proto_reset;
  logic live;
  logic in_xfer;
  logic abort;
  logic byte_end;
  logic addr_done;
  logic own_match;
  logic ack_me;
  logic async_hit;
  logic tx_load;
  logic rx_load;
  logic nak_smp;
  logic ev_dms;
  logic stat_wr;
  logic tx_wr;
  logic sum_w;
  logic irq_want;

  // single-cycle register port decode
  function automatic logic port_hit(input logic strobe,
                                    input logic [15:0] a,
                                    input logic [15:0] off);
    return strobe && (a == off);
  endfunction

  // ---------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------
  iss_pin_filter u_filt (
    .clk_sys(clk_sys),
    .rst(rst),
    .scl_pin(clock_line_pin_in),
    .sda_pin(data_line_pin_in),
    .rel_pin_n(bus_release_pin_n),
    .filter_on(ctl_r[CTL_FILT]),
    .bypass(async_on),
    .scl_f(scl_f),
    .sda_f(sda_f),
    .rel_n_s(rel_n_s)
  );

  // previous line levels for edge and condition detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  assign scl_rise = scl_f && !scl_d_r;
  assign scl_fall = !scl_f && scl_d_r;
  assign start_det = scl_f && scl_d_r && sda_d_r && !sda_f;
  assign stop_det = scl_f && scl_d_r && !sda_d_r && sda_f;
  assign async_on = ctl_r[CTL_ASYNC];

  // ---------------------------------------------------------------
  // bus release request
  // ---------------------------------------------------------------
  // counts low cycles, saturating
  always_ff @(posedge clk_sys) begin
    if (rst || rel_n_s) begin
      rel_cnt_r <= 3'h0;
    end else if (rel_cnt_r != REL_SAT) begin
      rel_cnt_r <= rel_cnt_r + 3'h1;
    end
  end

  assign rel_hit = ctl_r[CTL_BFR] && !rel_n_s &&
                   (rel_cnt_r == REL_MIN_CYC);
  assign proto_reset = rel_hit || !ctl_r[CTL_ON];
  assign live = !proto_reset;

  // ---------------------------------------------------------------
  // protocol decode
  // ---------------------------------------------------------------
  assign in_xfer = (state_r == ST_RX) || (state_r == ST_RACK) ||
                   (state_r == ST_TX) || (state_r == ST_MACK) ||
                   ((state_r == ST_AACK) && selected_r);
  assign abort = async_on && in_xfer;
  assign byte_end = scl_fall && (cnt_r == BYTE_BITS);
  assign addr_done = live && (state_r == ST_ADDR) && byte_end;
  assign own_match = (shift_r[7:1] == own_r);
  assign ack_me = own_match && ctl_r[CTL_COMM] && !async_on;
  // async match is NAKed, event raised
  assign async_hit = addr_done && own_match && async_on;
  assign tx_load = live && !async_on && scl_fall &&
                   (((state_r == ST_AACK) && selected_r && rw_r) ||
                    ((state_r == ST_MACK) && !shift_r[0]));
  assign rx_load = live && !abort && (state_r == ST_RX) && byte_end;
  assign nak_smp = live && !async_on && (state_r == ST_MACK) && scl_rise;
  // sensed line differs from driven bit
  assign ev_dms = live && !async_on && pres_r && scl_rise &&
                  (sda_f == drv_low_r);

  // ---------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------
  // release and stop go idle, bus released
  always_ff @(posedge clk_sys) begin
    if (rst || proto_reset || stop_det || abort) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      selected_r <= 1'h0;
      pres_r <= 1'h0;
      drv_low_r <= 1'h0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      cnt_r <= 4'h0;
      selected_r <= 1'h0;
      pres_r <= 1'h0;
      drv_low_r <= 1'h0;
    end else begin
      case (state_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            state_r <= (state_r == ST_ADDR) ? ST_AACK : ST_RACK;
            if (state_r == ST_ADDR) begin
              // async mode presents nothing to compare
              pres_r <= !async_on;
              drv_low_r <= ack_me;
              selected_r <= ack_me;
              rw_r <= shift_r[0];
            end else begin
              pres_r <= 1'h1;
              drv_low_r <= !ctl_r[CTL_NAKANS];
            end
          end
        end
        ST_AACK, ST_MACK: begin
          if (scl_rise && (state_r == ST_MACK)) begin
            shift_r[0] <= sda_f;
          end else if (tx_load) begin
            state_r <= ST_TX;
            shift_r <= tx_byte_r;
            cnt_r <= 4'h0;
            pres_r <= 1'h1;
            drv_low_r <= !tx_byte_r[7];
          end else if (scl_fall) begin
            state_r <= (selected_r && !rw_r) ? ST_RX : ST_IDLE;
            cnt_r <= 4'h0;
            pres_r <= 1'h0;
            drv_low_r <= 1'h0;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            state_r <= ST_MACK;
            pres_r <= 1'h0;
            drv_low_r <= 1'h0;
          end else if (scl_fall) begin
            shift_r <= {shift_r[6:0], 1'h0};
            drv_low_r <= !shift_r[6];
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            state_r <= ST_RX;
            cnt_r <= 4'h0;
            pres_r <= 1'h0;
            drv_low_r <= 1'h0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // bus busy from start to stop
  always_ff @(posedge clk_sys) begin
    if (rst || proto_reset || stop_det) begin
      busy_r <= 1'h0;
    end else if (start_det) begin
      busy_r <= 1'h1;
    end
  end

  // ---------------------------------------------------------------
  // event flags
  // ---------------------------------------------------------------
  assign stat_wr = port_hit(reg_wr, reg_addr, REG_STAT);

  // hardware sets, software clears by writing 1; set wins
  always_comb begin
    set_v = FLAG_RST;
    // stop or repeated start while addressed
    set_v[F_STOP] = live && selected_r && (stop_det || start_det);
    set_v[F_NAK] = nak_smp && sda_f;
    set_v[F_ASYNC] = async_hit;
    set_v[F_DMS] = ev_dms;
    set_v[F_BFR] = rel_hit;
    set_v[F_UOV] = !ctl_r[CTL_STR] &&
                   ((tx_load && !tx_pending_r) ||
                    (rx_load && rx_ready_r));
    flags_nxt = flags_r;
    // ACK after a sent byte clears NAK status
    if (nak_smp && !sda_f) begin
      flags_nxt[F_NAK] = 1'h0;
    end
    if (stat_wr) begin
      flags_nxt = flags_nxt & ~reg_wdata[FLAG_W-1:0];
    end
    flags_nxt = flags_nxt | set_v;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_r <= FLAG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign sum_w = |flags_r;
  // level request while summary and enable
  assign irq_want = sum_w && ien_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= irq_want;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // control, own address and interrupt enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_r <= CTL_RST;
      own_r <= OWN_RST;
      ien_r <= 1'h0;
    end else begin
      if (port_hit(reg_wr, reg_addr, REG_CTL)) begin
        ctl_r <= reg_wdata[CTL_W-1:0] & CTL_MASK;
      end
      if (port_hit(reg_wr, reg_addr, REG_OWN)) begin
        own_r <= reg_wdata[OWN_W-1:0];
      end
      if (port_hit(reg_wr, reg_addr, REG_IEN)) begin
        ien_r <= reg_wdata[IEN_BUS_EVENT_SUMMARY];
      end
    end
  end

  assign tx_wr = port_hit(reg_wr, reg_addr, REG_TX);

  // transmit and receive byte holding
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_byte_r <= 8'h00;
      rx_byte_r <= 8'h00;
      tx_pending_r <= 1'h0;
      tx_empty_r <= 1'h0;
      rx_ready_r <= 1'h0;
    end else begin
      if (tx_wr) begin
        tx_byte_r <= reg_wdata[7:0];
      end
      if (rx_load) begin
        rx_byte_r <= shift_r;
      end
      tx_pending_r <= tx_wr || (tx_pending_r && !tx_load);
      tx_empty_r <= tx_load || (tx_empty_r && !tx_wr);
      rx_ready_r <= rx_load ||
        (rx_ready_r && !port_hit(reg_rd, reg_addr, REG_RX));
    end
  end

  // read data in the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      rdata_r <= 16'h0000;
    end else begin
      case (reg_addr)
        REG_TX: rdata_r <= {8'h00, tx_byte_r};
        REG_RX: rdata_r <= {8'h00, rx_byte_r};
        REG_OWN: rdata_r <= {9'h000, own_r};
        REG_CTL: rdata_r <= {8'h00, ctl_r};
        REG_STAT: rdata_r <= {8'h00, sum_w, 1'h0, flags_r};
        REG_ACC: rdata_r <= {11'h000, rx_ready_r, tx_empty_r,
                             busy_r, selected_r, rw_r};
        REG_IEN: rdata_r <= {13'h0000, ien_r, 2'h0};
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign bus_event_irq = irq_r;
  assign data_line_pin_out = 1'h0;
  assign data_line_pin_oe = drv_low_r;
  assign clock_line_pin_out = 1'h0;
  assign clock_line_pin_oe = 1'h0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_summary_read: assert property (
    port_hit(reg_rd, reg_addr, REG_STAT) |=>
    reg_rdata[F_SUM] == $past(sum_w))
    else $error("summary bit read wrong");
  a_irq_level: assert property (
    ##1 bus_event_irq == $past(irq_want))
    else $error("irq level does not follow summary and enable");
  a_flag_sticky: assert property (
    !stat_wr |=> (($past(flags_r) & ~flags_r) & KEEP_MASK) == 6'h00)
    else $error("flag dropped without a write");
  a_w1c_stop: assert property (
    stat_wr && reg_wdata[F_STOP] && !set_v[F_STOP] |=>
    !flags_r[F_STOP])
    else $error("write 1 did not clear stop flag");
  a_rel_ignored: assert property (
    !ctl_r[CTL_BFR] && !flags_r[F_BFR] |=> !flags_r[F_BFR])
    else $error("release flag set while disabled");
  a_rel_frees: assert property (
    rel_hit |=> flags_r[F_BFR] && state_r == ST_IDLE &&
    !data_line_pin_oe)
    else $error("release request did not free the bus");
  a_async_quiet: assert property (
    async_on && $past(async_on) |-> !data_line_pin_oe)
    else $error("line driven in async detect mode");
  a_async_hit: assert property (
    async_hit |=> flags_r[F_ASYNC] && !selected_r)
    else $error("async hit not flagged or answered");
  a_comm_off: assert property (
    addr_done && !ctl_r[CTL_COMM] |=> !selected_r && !data_line_pin_oe)
    else $error("answered own address while inactive");
  a_no_dms_async: assert property (
    async_on && !flags_r[F_DMS] |=> !flags_r[F_DMS])
    else $error("mismatch raised in async detect mode");
  a_underrun: assert property (
    tx_load && !tx_pending_r && !ctl_r[CTL_STR] |=> flags_r[F_UOV])
    else $error("underrun not flagged");
  a_overrun: assert property (
    rx_load && rx_ready_r && !ctl_r[CTL_STR] |=>
    flags_r[F_UOV] && rx_ready_r)
    else $error("overrun not flagged");
  a_nak_record: assert property (
    nak_smp |=> flags_r[F_NAK] == $past(sda_f))
    else $error("master acknowledge not recorded");
  a_stop_seen: assert property (
    live && selected_r && stop_det |=>
    flags_r[F_STOP] && state_r == ST_IDLE && !selected_r)
    else $error("stop while addressed not handled");

  c_async_hit: cover property (async_hit);
  c_tx_byte: cover property (tx_load ##[1:400] nak_smp);
  c_rx_byte: cover property (rx_load);
  c_release: cover property (rel_hit);
endmodule
`default_nettype wire

// >>> verif/iss_i2c_master.sv
// iss_i2c_master: behavioural bus master driving clock and data lines
// assumes: open-drain lines with pull-ups resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module iss_i2c_master (
  output logic scl_low,
  output logic sda_low,
  input wire logic sda
);
  // bit period 160 ns, far below clk_sys / 8
  localparam time Q = 40ns;
  // idle: both lines released, clock stands still
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // data falls while clock high
  task automatic start();
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask
  // data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b0;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask
  // one clock: set data while low, sample while high
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #Q;
    scl_low = 1'b0;
    #Q;
    s = sda;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// >>> verif/i2c_slave_status_async_detect_tb.sv
// i2c_slave_status_async_detect_tb: register and bus tests of the core
// assumes: iss_i2c_master on the bus, pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); \
  end \
end
module i2c_slave_status_async_detect_tb import iss_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rel_n = 1'b1;
  logic jam = 1'b0;
  logic [15:0] rdata, d;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda, ack;
  logic [7:0] b;
  int bad_count = 0;
  int compares = 0;
  // wired-and of all pull-downs
  wire scl = ~(m_scl | scl_oe);
  wire sda = ~(m_sda | sda_oe | jam);
  initial forever #2.5 clk_sys = ~clk_sys;
  iss_status_core dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .clock_line_pin_in(scl),
    .clock_line_pin_out(scl_out), .clock_line_pin_oe(scl_oe),
    .data_line_pin_in(sda), .data_line_pin_out(sda_out),
    .data_line_pin_oe(sda_oe), .bus_release_pin_n(rel_n),
    .bus_event_irq(irq));
  iss_i2c_master mst (.scl_low(m_scl), .sda_low(m_sda), .sda(sda));
  // one-cycle register write
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read strobe, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic stat_is(input logic [15:0] e);
    rd(REG_STAT, d);
    `CHK(d, e)
  endtask
  // low pulse of n cycles on the release pin
  task automatic pulse(input int n);
    @(posedge clk_sys);
    rel_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rel_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog far beyond the expected run
  initial begin
    #200us;
    bad_count++;
    report_and_stop();
  end
  // test sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    stat_is(16'h0000);
    rd(16'h4370, d);
    `CHK(d, 16'h0000)
    wr(REG_OWN, 16'h002A);
    wr(REG_CTL, 16'h0084);
    mst.start();
    mst.xfer(8'h54, 1'b1, b, ack);
    mst.stop();
    `CHK(ack, 1'b1)
    stat_is(16'h0000);
    mst.start();
    mst.xfer(8'hC0, 1'b0, b, ack);
    mst.stop();
    stat_is(16'h0088);
    wr(REG_STAT, 16'h003F);
    $display("test comm off done");
    wr(REG_IEN, 16'h0004);
    wr(REG_CTL, 16'h0085);
    mst.start();
    mst.xfer(8'h54, 1'b1, b, ack);
    `CHK(ack, 1'b0)
    mst.xfer(8'h3C, 1'b1, b, ack);
    mst.xfer(8'hC3, 1'b1, b, ack);
    mst.stop();
    rd(REG_RX, d);
    `CHK(d, 16'h00C3)
    stat_is(16'h00A1);
    `CHK(irq, 1'b1)
    wr(REG_STAT, 16'h003F);
    stat_is(16'h0000);
    `CHK(irq, 1'b0)
    $display("test receive done");
    wr(REG_TX, 16'h00A5);
    mst.start();
    mst.xfer(8'h55, 1'b1, b, ack);
    mst.xfer(8'hFF, 1'b0, b, ack);
    `CHK(b, 8'hA5)
    jam <= 1'b1;
    mst.xfer(8'hFF, 1'b1, b, ack);
    jam <= 1'b0;
    mst.xfer(8'hFF, 1'b1, b, ack);
    `CHK(b, 8'hA5)
    mst.stop();
    stat_is(16'h00AB);
    wr(REG_STAT, 16'h003F);
    $display("test transmit done");
    wr(REG_CTL, 16'h0087);
    mst.start();
    mst.xfer(8'h54, 1'b1, b, ack);
    mst.stop();
    `CHK(ack, 1'b1)
    stat_is(16'h0084);
    wr(REG_CTL, 16'h0085);
    mst.start();
    mst.xfer(8'h54, 1'b1, b, ack);
    mst.stop();
    `CHK(ack, 1'b0)
    wr(REG_STAT, 16'h003F);
    $display("test async detect done");
    pulse(8);
    stat_is(16'h0000);
    wr(REG_CTL, 16'h0095);
    pulse(5);
    stat_is(16'h0000);
    pulse(8);
    stat_is(16'h0090);
    rd(REG_CTL, d);
    `CHK(d, 16'h0095)
    `CHK({scl_out, scl_oe, sda_out, sda_oe}, 4'h0)
    $display("test bus release done");
    report_and_stop();
  end
endmodule
`default_nettype wire
